// File: hw/tsf_consts.svh
`ifndef TSF_CONSTS_SVH
`define TSF_CONSTS_SVH

// register indices, byte address is four times the index
`define TSF_IDX_FILL      16'hb7a2
`define TSF_IDX_POP       16'hb7c0
`define TSF_IDX_CTRL      16'hb7e0
`define TSF_IDX_IRQ_ST    16'hb7e1
`define TSF_IDX_IRQ_CLR   16'hb7e2
`define TSF_IDX_IRQ_EN    16'hb7e3
`define TSF_ADDR_W        18

// fill state codes
`define TSF_FILL_CODE_NONE        2'h0
`define TSF_FILL_CODE_BELOW_HALF  2'h1
`define TSF_FILL_CODE_ABOVE_HALF  2'h2
`define TSF_FILL_CODE_FULL_LOST   2'h3

// control register fields
`define TSF_CTRL_MODE_LSB 0
`define TSF_CTRL_CLR_BIT  8
`define TSF_MODE_RST      2'h0

// interrupt bit positions
`define TSF_IRQ_W         3
`define TSF_IRQ_CAPT      0
`define TSF_IRQ_HALF      1
`define TSF_IRQ_LOST      2
`define TSF_IRQ_EN_RST    3'h0

// stamp layout and default depth
`define TSF_STAMP_W       56
`define TSF_LO_W          32
`define TSF_HI_W          24
`define TSF_FIFO_DEPTH    64

`endif

// File: hw/tsf_pkg.sv
`include "tsf_consts.svh"

package tsf_pkg;

    typedef enum logic [1:0] {
        TSF_PLAIN_COUNT_MODE       = 2'b00,
        TSF_CLEAR_ON_RUN_MODE      = 2'b01,
        TSF_SECONDS_REFERENCE_MODE = 2'b10,
        TSF_MODE_SPARE             = 2'b11
    } tsf_mode_t;

    typedef struct packed {
        logic [`TSF_LO_W-1:0]  cnt_lo;
        logic [`TSF_HI_W-1:0]  cnt_hi;
        logic                  word_hi;
        logic                  lost;
        logic [2:0]            sec_sync;
        logic                  sec_lvl;
        tsf_mode_t             mode;
        logic [`TSF_IRQ_W-1:0] irq_st;
        logic [`TSF_IRQ_W-1:0] irq_en;
        logic                  above_half;
        logic [31:0]           rd_data;
        logic                  irq;
    } tsf_top_st_t;

endpackage

// File: hw/tsf_fifo_if.sv
`timescale 1ns/1ps

interface tsf_fifo_if #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 56
);
    logic                       push_valid;
    logic                       push_ready;
    logic [WIDTH-1:0]           push_data;
    logic                       pop;
    logic [WIDTH-1:0]           head_data;
    logic [$clog2(DEPTH):0]     count;
    logic                       empty;
    logic                       full;

    modport fifo (
        input  push_valid, push_data, pop,
        output push_ready, head_data, count, empty, full
    );
    modport user (
        output push_valid, push_data, pop,
        input  push_ready, head_data, count, empty, full
    );
endinterface

// File: hw/tsf_fifo.sv
`timescale 1ns/1ps

module tsf_fifo #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 56
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    // storage port
    tsf_fifo_if.fifo  fif
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } tsf_fifo_st_t;

    tsf_fifo_st_t     q;
    tsf_fifo_st_t     d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             do_push;
    logic             do_pop;

    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("tsf_fifo: DEPTH must be a power of two, at least 4");
    end

    assign fif.full       = (q.cnt == (AW+1)'(DEPTH));
    assign fif.empty      = (q.cnt == '0);
    assign fif.push_ready = !fif.full;
    assign fif.count      = q.cnt;
    assign fif.head_data  = mem[q.rp];
    assign do_push        = fif.push_valid && !fif.full;
    assign do_pop         = fif.pop && !fif.empty;

    always_comb begin
        d = q;
        if (do_push) begin
            d.wp = q.wp + 1'b1;
        end
        if (do_pop) begin
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge core_clk_i) begin
        if (do_push) begin
            mem[q.wp] <= fif.push_data;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// File: hw/tsf_top.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "tsf_consts.svh"

// Summary of operation
// R01: fill state register reads code 0 while the stamp store is empty.
// R02: code 1 when entries exist but no more than half is filled.
// R03: code 2 when more than half of the store is occupied.
// R04: code 3 when full or once a capture has been lost; this takes precedence over codes 0 to 2.
// R05: reading the pop word register returns and removes one head word.
// R06: pop word read on empty store returns zero, nothing changes.
// R07: host needs two word reads to collect one whole stamp.
// R08: stamps are 56 bits, zero-extended to a 64-bit two-word entry.
// R09: counter advances once per sample enable since the last clear.
// R10: counter value is stored when the internal trigger is recognised.
// R11: capture latency is fixed by the event input timing, not varied.
// R12: each trigger yields low word then high word, triggers in order.
// R13: gate openings and closings each store one stamp, alternating.
// R14: seconds mode: first word sample count, second word seconds count.
// R15: seconds mode: low part clears on seconds edge, high counts seconds.
// R16: clear-on-run mode clears the counter at each acquisition start.
// R17: full store drops captures; lost state stays until reset.
// R18: entry words are read out low word first, then high word.
module tsf_top
    import tsf_pkg::*;
#(
    parameter int DEPTH = `TSF_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_b_i,
    // register port
    input  wire logic [`TSF_ADDR_W-1:0] addr_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rdata_o,
    // acquisition events
    input  wire logic                   sample_en_i,
    input  wire logic                   trig_evt_i,
    input  wire logic                   gate_open_i,
    input  wire logic                   gate_close_i,
    input  wire logic                   acq_start_i,
    // seconds pin
    input  wire logic                   seconds_pin_i,
    // interrupt
    output logic                        irq_o
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);

    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("tsf_top: DEPTH must be a power of two, at least 4");
    end

    function automatic logic hit(input logic [`TSF_ADDR_W-1:0] a, input logic [15:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    // R01 R02 R03 R04 fill code
    function automatic logic [1:0] fill_code(input logic [CW-1:0] c, input logic f,
                                             input logic l);
        if (f || l) begin
            fill_code = `TSF_FILL_CODE_FULL_LOST;
        end else if (c > HALF) begin
            fill_code = `TSF_FILL_CODE_ABOVE_HALF;
        end else if (c != '0) begin
            fill_code = `TSF_FILL_CODE_BELOW_HALF;
        end else begin
            fill_code = `TSF_FILL_CODE_NONE;
        end
    endfunction

    logic [1:0]  rst_sync_q;
    logic        rst_b_q;
    tsf_top_st_t q;
    tsf_top_st_t d;
    logic        capt_c;
    logic        push_c;
    logic        pop_c;
    logic        sec_edge_c;
    logic        clr_c;
    logic        rd_pop_c;
    logic        rd_fill_c;

    tsf_fifo_if #(.DEPTH(DEPTH), .WIDTH(`TSF_STAMP_W)) fif ();

    tsf_fifo #(
        .DEPTH (DEPTH),
        .WIDTH (`TSF_STAMP_W)
    ) u_tsf_fifo (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_q),
        .fif        (fif)
    );

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b_q = rst_sync_q[1];

    // R10 store at recognition
    assign fif.push_valid = push_c;
    // R08 56-bit stamp
    assign fif.push_data  = {q.cnt_hi, q.cnt_lo};
    // R12 in-order readout
    assign fif.pop        = pop_c;

    always_comb begin
        d          = q;
        pop_c      = 1'b0;
        sec_edge_c = 1'b0;
        rd_pop_c   = rd_i && hit(addr_i, `TSF_IDX_POP);
        rd_fill_c  = rd_i && hit(addr_i, `TSF_IDX_FILL);
        clr_c      = wr_i && hit(addr_i, `TSF_IDX_CTRL) && wdata_i[`TSF_CTRL_CLR_BIT];
        // R13 every gate edge stores
        capt_c     = trig_evt_i || gate_open_i || gate_close_i;
        // R11 same-cycle capture
        push_c     = capt_c;

        d.sec_sync = {q.sec_sync[1:0], seconds_pin_i};
        if (q.sec_sync[1] == q.sec_sync[2]) begin
            d.sec_lvl  = q.sec_sync[2];
            sec_edge_c = q.sec_sync[2] && !q.sec_lvl;
        end

        // R09 count sample clocks
        if (sample_en_i) begin
            if (q.mode == TSF_SECONDS_REFERENCE_MODE) begin
                d.cnt_lo = q.cnt_lo + 1'b1;
            end else begin
                {d.cnt_hi, d.cnt_lo} = {q.cnt_hi, q.cnt_lo} + 56'h1;
            end
        end
        // R15 seconds split counter
        if (q.mode == TSF_SECONDS_REFERENCE_MODE && sec_edge_c) begin
            d.cnt_lo = '0;
            d.cnt_hi = q.cnt_hi + 1'b1;
        end
        // R16 clear at start
        if (clr_c || (q.mode == TSF_CLEAR_ON_RUN_MODE && acq_start_i)) begin
            d.cnt_lo = '0;
            d.cnt_hi = '0;
        end

        d.rd_data = 32'h0;
        if (rd_i) begin
            if (rd_pop_c) begin
                // R06 empty read gives zero
                if (!fif.empty) begin
                    // R18 low word first
                    if (!q.word_hi) begin
                        // R14 first word count
                        d.rd_data = fif.head_data[`TSF_LO_W-1:0];
                        d.word_hi = 1'b1;
                    end else begin
                        // R05 pop after high word
                        d.rd_data = {8'h0, fif.head_data[`TSF_STAMP_W-1:`TSF_LO_W]};
                        d.word_hi = 1'b0;
                        pop_c     = 1'b1;
                    end
                end
            end else if (rd_fill_c) begin
                d.rd_data = {30'h0, fill_code(fif.count, fif.full, q.lost)};
            end else if (hit(addr_i, `TSF_IDX_CTRL)) begin
                d.rd_data = {30'h0, q.mode};
            end else if (hit(addr_i, `TSF_IDX_IRQ_ST)) begin
                d.rd_data = {29'h0, q.irq_st};
            end else if (hit(addr_i, `TSF_IDX_IRQ_EN)) begin
                d.rd_data = {29'h0, q.irq_en};
            end
        end

        if (wr_i) begin
            if (hit(addr_i, `TSF_IDX_CTRL)) begin
                d.mode = tsf_mode_t'(wdata_i[`TSF_CTRL_MODE_LSB +: 2]);
            end else if (hit(addr_i, `TSF_IDX_IRQ_CLR)) begin
                d.irq_st = q.irq_st & ~wdata_i[`TSF_IRQ_W-1:0];
            end else if (hit(addr_i, `TSF_IDX_IRQ_EN)) begin
                d.irq_en = wdata_i[`TSF_IRQ_W-1:0];
            end
        end

        // R17 drop and keep lost
        if (capt_c && fif.full) begin
            d.lost = 1'b1;
            d.irq_st[`TSF_IRQ_LOST] = 1'b1;
        end
        if (capt_c && !fif.full) begin
            d.irq_st[`TSF_IRQ_CAPT] = 1'b1;
        end
        d.above_half = (fif.count > HALF);
        if (d.above_half && !q.above_half) begin
            d.irq_st[`TSF_IRQ_HALF] = 1'b1;
        end
        d.irq = |(d.irq_st & d.irq_en);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_q) begin
        if (!rst_b_q) begin
            q        <= '0;
            q.mode   <= tsf_mode_t'(`TSF_MODE_RST);
            q.irq_en <= `TSF_IRQ_EN_RST;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rd_data;
    assign irq_o   = q.irq;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_q);

    // fill state codes
    a_fill_none: assert property ( // R01
        rd_fill_c && fif.empty && !q.lost |=> rdata_o == 32'h0)
        else $error("fill state not zero while empty");
    a_fill_below: assert property ( // R02
        rd_fill_c && !fif.empty && fif.count <= HALF && !q.lost |=> rdata_o == 32'h1)
        else $error("fill state not one below half");
    a_fill_above: assert property ( // R03
        rd_fill_c && fif.count > HALF && !fif.full && !q.lost |=> rdata_o == 32'h2)
        else $error("fill state not two above half");
    a_fill_full: assert property ( // R04
        rd_fill_c && fif.full |=> rdata_o == 32'h3)
        else $error("fill state not three when full");

    // pop word path
    a_pop_word: assert property ( // R05
        rd_pop_c && !fif.empty && q.word_hi
        |=> fif.count == $past(fif.count) - CW'(1) + CW'($past(push_c && !fif.full)))
        else $error("high word read did not remove entry");
    a_empty_read: assert property ( // R06
        rd_pop_c && fif.empty |=> rdata_o == 32'h0 && q.word_hi == $past(q.word_hi))
        else $error("empty pop read not zero or state moved");
    a_high_zext: assert property ( // R08
        rd_pop_c && !fif.empty && q.word_hi |=> rdata_o[31:24] == 8'h0)
        else $error("high word not zero extended");
    a_low_first: assert property ( // R18
        rd_pop_c && !fif.empty && !q.word_hi
        |=> q.word_hi && rdata_o == $past(fif.head_data[31:0]))
        else $error("low word not returned first");
    a_word_hold: assert property ( // R12
        !rd_pop_c |=> q.word_hi == $past(q.word_hi))
        else $error("word pointer moved without pop read");
    a_rdata_idle: assert property (
        !rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero without read");

    // counter and capture
    a_count_step: assert property ( // R09
        sample_en_i && q.mode == TSF_PLAIN_COUNT_MODE && !clr_c
        |=> {q.cnt_hi, q.cnt_lo} == $past({q.cnt_hi, q.cnt_lo}) + 56'h1)
        else $error("counter did not advance");
    a_clear_cmd: assert property ( // R09
        clr_c |=> q.cnt_lo == 32'h0 && q.cnt_hi == 24'h0)
        else $error("clear command did not zero counter");
    a_capture_data: assert property ( // R10
        capt_c && !fif.full
        |=> fif.count == $past(fif.count) + CW'(1) - CW'($past(pop_c)))
        else $error("capture not stored");
    a_gate_store: assert property ( // R13
        (gate_open_i || gate_close_i) && !fif.full
        |=> fif.count == $past(fif.count) + CW'(1) - CW'($past(pop_c)))
        else $error("gate edge not stored");
    a_sec_split: assert property ( // R15
        q.mode == TSF_SECONDS_REFERENCE_MODE && sec_edge_c && !clr_c
        |=> q.cnt_lo == 32'h0 && q.cnt_hi == $past(q.cnt_hi) + 24'h1)
        else $error("seconds edge did not split counter");
    a_sec_count: assert property ( // R14
        q.mode == TSF_SECONDS_REFERENCE_MODE && sample_en_i && !sec_edge_c && !clr_c
        |=> q.cnt_lo == $past(q.cnt_lo) + 32'h1 && q.cnt_hi == $past(q.cnt_hi))
        else $error("seconds mode count moved wrongly");
    a_sync_agree: assert property ( // R15
        sec_edge_c |-> q.sec_sync[2] && q.sec_sync[1] && !q.sec_lvl)
        else $error("seconds edge taken before pin settled");
    a_start_clear: assert property ( // R16
        q.mode == TSF_CLEAR_ON_RUN_MODE && acq_start_i |=> q.cnt_lo == 32'h0 && q.cnt_hi == 24'h0)
        else $error("start did not clear counter");
    a_drop_lost: assert property ( // R17
        capt_c && fif.full && !pop_c |=> q.lost && fif.full ##1 q.lost)
        else $error("full capture not dropped or lost cleared");
    a_lost_sticky: assert property ( // R17
        q.lost |=> q.lost)
        else $error("lost state cleared before reset");

    // interrupt
    a_irq_level: assert property (
        (q.irq_st & q.irq_en) != '0 |-> irq_o)
        else $error("interrupt low with enabled status set");
    a_irq_low: assert property (
        (q.irq_st & q.irq_en) == '0 |-> !irq_o)
        else $error("interrupt high with no enabled status");
    a_capt_irq: assert property (
        capt_c && !fif.full |=> q.irq_st[`TSF_IRQ_CAPT])
        else $error("capture status not set");
    a_half_irq: assert property (
        fif.count > HALF && !q.above_half |=> q.irq_st[`TSF_IRQ_HALF])
        else $error("half status not set");

    c_two_word_read: cover property (rd_pop_c && !fif.empty && !q.word_hi ##1
        rd_pop_c && q.word_hi);
    c_fill_full: cover property (fif.full && capt_c);
    c_sec_edge: cover property (q.mode == TSF_SECONDS_REFERENCE_MODE && sec_edge_c);
    c_empty_read: cover property (rd_pop_c && fif.empty);
    c_irq: cover property ($rose(irq_o));
endmodule

// File: testbench/tsf_host_model.sv
`timescale 1ns/1ps
`include "tsf_consts.svh"

module tsf_host_model (
    // clock
    input  wire logic                   core_clk_i,
    // register port
    output logic      [`TSF_ADDR_W-1:0] addr_o,
    output logic      [31:0]            wdata_o,
    output logic                        wr_o,
    output logic                        rd_o,
    input  wire logic [31:0]            rdata_i
);
    initial begin
        addr_o  = '0;
        wdata_o = '0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // one-cycle write, bus scrambled once released
    task automatic wr_reg(input logic [15:0] idx, input logic [31:0] d);
        @(posedge core_clk_i);
        addr_o  <= {idx, 2'b00};
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge core_clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~{idx, 2'b00};
        wdata_o <= ~d;
    endtask

    // one-cycle read, data taken in the following cycle
    task automatic rd_reg(input logic [15:0] idx, output logic [31:0] d);
        @(posedge core_clk_i);
        addr_o <= {idx, 2'b00};
        rd_o   <= 1'b1;
        @(posedge core_clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~{idx, 2'b00};
        @(posedge core_clk_i);
        d = rdata_i;
    endtask

    task automatic rd_stamp(output logic [63:0] s);
        logic [31:0] lo;
        logic [31:0] hi;
        rd_reg(`TSF_IDX_POP, lo);
        rd_reg(`TSF_IDX_POP, hi);
        s = {hi, lo};
    endtask
endmodule

// File: testbench/tsf_top_tb_top.sv
`timescale 1ns/1ps
`include "tsf_consts.svh"

module tsf_top_tb_top;
    localparam int DEPTH = 4;
    logic                   core_clk_i;
    logic                   rst_b_i;
    logic [`TSF_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
    logic [31:0]            rdata;
    logic                   sample_en;
    logic [2:0]             evt;
    logic                   acq_start;
    logic                   sec_pin;
    logic                   irq;
    logic                   smp_on;
    logic                   clr;
    logic                   sec_jump;
    logic [55:0]            exp_cnt;
    logic [55:0]            exp_q[$];
    logic                   exp_lost;
    logic [1:0]             exp_mode;
    logic [31:0]            d;
    integer                 seed = 32'h05f3;
    int                     n_fail;
    int                     comparisons;

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    tsf_top #(.DEPTH(DEPTH)) u_tsf_top (
        .core_clk_i    (core_clk_i),
        .rst_b_i       (rst_b_i),
        .addr_i        (addr),
        .wdata_i       (wdata),
        .wr_i          (wr),
        .rd_i          (rd),
        .rdata_o       (rdata),
        .sample_en_i   (sample_en),
        .trig_evt_i    (evt[0]),
        .gate_open_i   (evt[1]),
        .gate_close_i  (evt[2]),
        .acq_start_i   (acq_start),
        .seconds_pin_i (sec_pin),
        .irq_o         (irq)
    );

    tsf_host_model u_tsf_host_model (
        .core_clk_i (core_clk_i),
        .addr_o     (addr),
        .wdata_o    (wdata),
        .wr_o       (wr),
        .rd_o       (rd),
        .rdata_i    (rdata)
    );

    always @(posedge core_clk_i) begin
        sample_en <= smp_on & 1'($random(seed));
    end

    // reference counter and stamp store
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            exp_q.delete();
            exp_cnt  = '0;
            exp_lost = 1'b0;
            exp_mode = 2'h0;
        end else begin
            if (|evt) begin
                if (exp_q.size() < DEPTH) exp_q.push_back(exp_cnt);
                else exp_lost = 1'b1;
            end
            clr = exp_mode == 2'h1 && acq_start;
            if (exp_mode == 2'h2) begin
                if (sec_jump) exp_cnt = {exp_cnt[55:32] + 24'h1, 32'h0};
                else if (sample_en) exp_cnt[31:0] = exp_cnt[31:0] + 32'h1;
            end else if (sample_en) begin
                exp_cnt = exp_cnt + 56'h1;
            end
            if (wr && addr == {`TSF_IDX_CTRL, 2'b00}) begin
                clr      = clr | wdata[8];
                exp_mode = wdata[1:0];
            end
            if (clr) exp_cnt = '0;
        end
    end

    function automatic logic [31:0] fill_code(input int n, input logic lost);
        if (lost || n >= DEPTH) return 32'h3;
        if (n > DEPTH / 2) return 32'h2;
        if (n > 0) return 32'h1;
        return 32'h0;
    endfunction

    task automatic report_and_stop();
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ev(input int k);
        @(posedge core_clk_i);
        evt <= 3'h1 << k;
        @(posedge core_clk_i);
        evt <= 3'h0;
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        u_tsf_host_model.rd_reg(idx, d);
        chk(d, exp);
    endtask

    task automatic chk_stamp();
        logic [63:0] s;
        logic [55:0] e;
        u_tsf_host_model.rd_stamp(s);
        e = exp_q.size() > 0 ? exp_q.pop_front() : 56'h0;
        chk(s[31:0], e[31:0]);
        chk(s[63:32], {8'h0, e[55:32]});
    endtask

    task automatic do_reset();
        rst_b_i <= 1'b0;
        smp_on  <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
    endtask

    initial begin
        repeat (100000) @(posedge core_clk_i);
        n_fail++;
        report_and_stop();
    end

    initial begin
        rst_b_i   = 1'b0;
        evt       = 3'h0;
        acq_start = 1'b0;
        sec_pin   = 1'b0;
        smp_on    = 1'b0;
        sec_jump  = 1'b0;
        do_reset();
        rd_chk(`TSF_IDX_FILL, 32'h0);
        rd_chk(`TSF_IDX_POP, 32'h0);
        rd_chk(`TSF_IDX_FILL, 32'h0);
        rd_chk(16'h0001, 32'h0);
        rd_chk(`TSF_IDX_IRQ_EN, 32'h0);
        u_tsf_host_model.wr_reg(`TSF_IDX_CTRL, 32'h100);
        u_tsf_host_model.wr_reg(`TSF_IDX_IRQ_EN, 32'h7);
        smp_on <= 1'b1;
        for (int i = 0; i <= DEPTH; i++) begin
            repeat (1 + ($random(seed) & 7)) @(posedge core_clk_i);
            ev(i % 3);
            u_tsf_host_model.rd_reg(`TSF_IDX_FILL, d);
            chk(d, fill_code(exp_q.size(), exp_lost));
        end
        chk({31'h0, irq}, 32'h1);
        rd_chk(`TSF_IDX_IRQ_ST, 32'h7);
        u_tsf_host_model.wr_reg(`TSF_IDX_IRQ_CLR, 32'h7);
        repeat (2) @(posedge core_clk_i);
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < DEPTH; i++) chk_stamp();
        rd_chk(`TSF_IDX_FILL, 32'h3);
        rd_chk(`TSF_IDX_POP, 32'h0);
        do_reset();
        smp_on <= 1'b1;
        rd_chk(`TSF_IDX_FILL, 32'h0);
        ev(0);
        repeat (3) @(posedge core_clk_i);
        chk({31'h0, irq}, 32'h0);
        rd_chk(`TSF_IDX_IRQ_ST, 32'h1);
        chk_stamp();
        for (int m = 0; m < 4; m++) begin
            u_tsf_host_model.wr_reg(`TSF_IDX_CTRL, 32'h100 | m);
            repeat (6) @(posedge core_clk_i);
            acq_start <= 1'b1;
            @(posedge core_clk_i);
            acq_start <= 1'b0;
            repeat (5) @(posedge core_clk_i);
            ev(m % 3);
            chk_stamp();
        end
        u_tsf_host_model.wr_reg(`TSF_IDX_CTRL, 32'h102);
        rd_chk(`TSF_IDX_CTRL, 32'h2);
        rd_chk(`TSF_IDX_IRQ_CLR, 32'h0);
        repeat (10) @(posedge core_clk_i);
        smp_on <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        sec_pin  <= 1'b1;
        sec_jump <= 1'b1;
        @(posedge core_clk_i);
        sec_jump <= 1'b0;
        repeat (9) @(posedge core_clk_i);
        smp_on   <= 1'b1;
        repeat (7) @(posedge core_clk_i);
        ev(0);
        ev(2);
        sec_pin <= 1'b0;
        chk_stamp();
        chk_stamp();
        report_and_stop();
    end
endmodule
